// *** vcmg_pkg.sv ***
// Purpose: Shared constants and types for the voltage code monitor with pin reuse
// Assumes: 10 MHz aclk, AXI4-Lite register access with 32-bit data
// Notes:   Register indices are kept as printed; byte address is four times the index
package vcmg_pkg;
  // Clock and change-window timing
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned CHG_WIN_NS    = 11000;
  // Longest window, so rounded down to whole cycles
  localparam int unsigned CHG_WIN_CYC   = (CHG_WIN_NS / CLK_PERIOD_NS) > 0 ? (CHG_WIN_NS / CLK_PERIOD_NS) : 1;

  // Register indices (byte address = index * 4)
  localparam logic [7:0] IDX_INT_STATUS_TWO = 8'h42;
  localparam logic [7:0] IDX_VOLTAGE_CODE   = 8'h43;
  localparam logic [7:0] IDX_INT_MASK_TWO   = 8'h75;
  localparam logic [7:0] IDX_CONFIG_FIVE    = 8'h7C;

  // Field positions
  localparam int unsigned STS_SUPPLY_OR_CODE_BIT = 0;
  localparam int unsigned CFG5_GPIO_MODE_BIT     = 4;
  localparam int unsigned CFG5_IND_DIR_BIT       = 3;
  localparam int unsigned CFG5_IND_LEVEL_BIT     = 2;
  localparam int unsigned CODE_SHARED_BIT        = 5;
  localparam int unsigned CODE_DEDICATED_W       = 5;
  localparam int unsigned CODE_W                 = 6;

  // Reset values
  localparam logic [7:0] RST_VOLTAGE_CODE = 8'h00;
  localparam logic [7:0] RST_INT_STATUS   = 8'h00;
  localparam logic [7:0] RST_INT_MASK     = 8'h00;
  localparam logic [7:0] RST_CONFIG_FIVE  = 8'h00;

  // AXI response codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // Writable part of the code register: select, threshold, output polarities
  typedef struct packed {
    logic                     shared_pin_function_select;
    logic                     input_threshold_select;
    logic [CODE_W-1:0]        pin_level;
  } vcmg_code_reg_t;

  // Drive bundle for one group of two-way pins
  typedef struct packed {
    logic [CODE_W-1:0] o;
    logic [CODE_W-1:0] oe;
  } vcmg_pin_drive_t;
endpackage

// *** vcmg_sync.sv ***
// Purpose: Two-flop synchroniser for a bus of independent level inputs
// Assumes: Each bit is treated alone; no bus coherence is implied
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ns
module vcmg_sync #(
  parameter int unsigned W = 6
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  if (W == 0) begin : g_w_check
    $error("W must be at least one bit");
  end

  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] q_r;
  logic [W-1:0] q_nxt;

  // Shift the pins through two stages
  always_comb begin
    meta_nxt = d;
    q_nxt    = meta_r;
  end

  // Register both stages
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_r <= '0;
      q_r    <= '0;
    end else begin
      meta_r <= meta_nxt;
      q_r    <= q_nxt;
    end
  end

  assign q = q_r;
endmodule

// *** vcmg_chg_det.sv ***
// Purpose: Flags a code change against a reference taken once per window
// Assumes: Input already synchronised to aclk
// Notes:   Window reference trades a deep delay line for one register
`timescale 1ns/1ns
module vcmg_chg_det #(
  parameter int unsigned W   = 6,
  parameter int unsigned WIN = 110
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [W-1:0] code,
  output logic              change
);
  localparam int unsigned CW = $clog2(WIN + 1);

  if (WIN == 0) begin : g_win_check
    $error("WIN must be at least one cycle");
  end

  logic [W-1:0]  ref_r;
  logic [W-1:0]  ref_nxt;
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic          wrap;

  // Reload the reference every window so a change is seen within it
  always_comb begin
    wrap    = (cnt_r == CW'(WIN - 1));
    cnt_nxt = wrap ? '0 : cnt_r + CW'(1);
    ref_nxt = wrap ? code : ref_r;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ref_r <= '0;
      cnt_r <= '0;
    end else begin
      ref_r <= ref_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // Level while the code differs from the window reference
  assign change = (code != ref_r);
endmodule

// *** vcmg_top.sv ***
// Purpose: Voltage code monitor with reusable code pins, reached over AXI4-Lite
// Assumes: Pins synchronous enough to pass a two-flop synchroniser; single clock
// Notes:   Supply out-of-limit arrives as a pulse or level from the measurement path
`timescale 1ns/1ns
// Notes on behaviour
// - Code register bits 0-4 show dedicated inputs
// - Bit 5 zero unless shared pin codes
// - Bit 6 selects lower input threshold
// - Bit 7 selects shared pin function, readable
// - Select clear: status bit 0 reports supply
// - Select set: status bit 0 reports changes
// - Flag code differing from the reference taken once per 11 us window
// - Code change raises alert unless masked
// - Config five bit 4 makes code pins outputs
// - Code bit writes set output pin polarity
// - Config five bits 3:2 steer independent pin
// - Index five is a general pin only while shared pin codes
module vcmg_top #(
  parameter int unsigned ADDR_W = 10
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite slave
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Code pins 0-4 dedicated, 5 shared with supply measurement
  input  wire logic [5:0]        voltage_code_i,
  output logic      [5:0]        voltage_code_o,
  output logic      [5:0]        voltage_code_oe,
  // Independent general pin, numbered six
  input  wire logic              independent_general_pin_i,
  output logic                   independent_general_pin_o,
  output logic                   independent_general_pin_oe,
  // Analogue controls and measurement status
  input  wire logic              supply_out_of_limit,
  output logic                   input_threshold_select,
  output logic                   shared_pin_function_select,
  output logic                   irq
);
  if (ADDR_W < 10) begin : g_addr_w_check
    $error("ADDR_W must reach index 0x7C");
  end

  localparam int unsigned CW = vcmg_pkg::CODE_W;

  // Register state
  vcmg_pkg::vcmg_code_reg_t code_r;
  vcmg_pkg::vcmg_code_reg_t code_nxt;
  logic [7:0]               status_r;
  logic [7:0]               status_nxt;
  logic [7:0]               mask_r;
  logic [7:0]               mask_nxt;
  logic [7:0]               cfg5_r;
  logic [7:0]               cfg5_nxt;

  // Bus state
  logic [ADDR_W-1:0] awaddr_r;
  logic [ADDR_W-1:0] awaddr_nxt;
  logic              aw_full_r;
  logic              aw_full_nxt;
  logic [7:0]        wdata_r;
  logic [7:0]        wdata_nxt;
  logic              wlane0_r;
  logic              wlane0_nxt;
  logic              w_full_r;
  logic              w_full_nxt;
  logic              bvalid_r;
  logic              bvalid_nxt;
  logic [1:0]        bresp_r;
  logic [1:0]        bresp_nxt;
  logic              rvalid_r;
  logic              rvalid_nxt;
  logic [31:0]       rdata_r;
  logic [31:0]       rdata_nxt;
  logic [1:0]        rresp_r;
  logic [1:0]        rresp_nxt;

  // Pin sampling
  logic [CW-1:0] code_sync;
  logic          ind_sync;
  logic          code_change;
  logic          gpio_mode;
  logic [CW-1:0] code_is_input;
  logic [7:0]    code_read;

  // Code and independent pins through two flops before any use
  vcmg_sync #(
    .W(CW + 1)
  ) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       ({independent_general_pin_i, voltage_code_i}),
    .q       ({ind_sync, code_sync})
  );

  // Compare the synchronised code against the window reference
  vcmg_chg_det #(
    .W   (CW),
    .WIN (vcmg_pkg::CHG_WIN_CYC)
  ) u_chg (
    .aclk    (aclk),
    .aresetn (aresetn),
    .code    (code_sync),
    .change  (code_change)
  );

  // Pin function
  assign gpio_mode = cfg5_r[vcmg_pkg::CFG5_GPIO_MODE_BIT];

  // Which pins currently act as code inputs; index 5 only when shared
  genvar gi;
  generate
    for (gi = 0; gi < CW; gi++) begin : g_pin
      if (gi == vcmg_pkg::CODE_SHARED_BIT) begin : g_shared
        assign code_is_input[gi] = code_r.shared_pin_function_select;
      end else begin : g_dedicated
        assign code_is_input[gi] = 1'b1;
      end
      // Code inputs become outputs in general-purpose mode
      assign voltage_code_oe[gi] = gpio_mode & code_is_input[gi];
      assign voltage_code_o[gi]  = code_r.pin_level[gi];
    end
  endgenerate

  // Independent pin is its own choice; index five is a general pin only while the shared pin carries code
  assign independent_general_pin_oe = cfg5_r[vcmg_pkg::CFG5_IND_DIR_BIT];
  assign independent_general_pin_o  = cfg5_r[vcmg_pkg::CFG5_IND_LEVEL_BIT];

  assign input_threshold_select     = code_r.input_threshold_select;
  assign shared_pin_function_select = code_r.shared_pin_function_select;

  // Read view of the code register
  always_comb begin
    code_read      = {code_r.shared_pin_function_select, code_r.input_threshold_select, 6'h00};
    code_read[4:0] = code_sync[4:0];
    code_read[5]   = code_r.shared_pin_function_select & code_sync[5];
  end

  // AXI4-Lite write path
  logic       wr_fire;
  logic [7:0] wr_idx;
  logic       wr_hit;

  // Hold address and data apart; commit when both are in and B is free
  always_comb begin
    awaddr_nxt  = awaddr_r;
    aw_full_nxt = aw_full_r;
    wdata_nxt   = wdata_r;
    wlane0_nxt  = wlane0_r;
    w_full_nxt  = w_full_r;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    wr_fire     = aw_full_r & w_full_r & ~bvalid_r;
    wr_idx      = awaddr_r[9:2];
    wr_hit      = (awaddr_r[1:0] == 2'h0) && ((awaddr_r >> 10) == '0) &&
                  (wr_idx == vcmg_pkg::IDX_INT_STATUS_TWO || wr_idx == vcmg_pkg::IDX_VOLTAGE_CODE ||
                   wr_idx == vcmg_pkg::IDX_INT_MASK_TWO || wr_idx == vcmg_pkg::IDX_CONFIG_FIVE);
    if (s_axi_awvalid && s_axi_awready) begin
      awaddr_nxt  = s_axi_awaddr;
      aw_full_nxt = 1'b1;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      wdata_nxt  = s_axi_wdata[7:0];
      wlane0_nxt = s_axi_wstrb[0];
      w_full_nxt = 1'b1;
    end
    if (wr_fire) begin
      aw_full_nxt = 1'b0;
      w_full_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = wr_hit ? vcmg_pkg::RESP_OKAY : vcmg_pkg::RESP_DECERR;
    end
    if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
  end

  assign s_axi_awready = ~aw_full_r;
  assign s_axi_wready  = ~w_full_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;

  // Register updates
  logic wr_en;
  logic status_event;

  // Status bit 0 source follows the shared pin function
  assign status_event = code_r.shared_pin_function_select ? code_change : supply_out_of_limit;

  always_comb begin
    code_nxt   = code_r;
    mask_nxt   = mask_r;
    cfg5_nxt   = cfg5_r;
    status_nxt = status_r;
    wr_en      = wr_fire & wr_hit & wlane0_r;
    if (wr_en) begin
      unique case (wr_idx)
        vcmg_pkg::IDX_VOLTAGE_CODE: begin
          code_nxt = vcmg_pkg::vcmg_code_reg_t'(wdata_r);
        end
        vcmg_pkg::IDX_INT_MASK_TWO: begin
          mask_nxt = wdata_r;
        end
        vcmg_pkg::IDX_CONFIG_FIVE: begin
          cfg5_nxt = wdata_r;
        end
        vcmg_pkg::IDX_INT_STATUS_TWO: begin
          status_nxt = status_r & ~wdata_r;
        end
        default: begin
        end
      endcase
    end
    // Setting after the clear keeps an event that lands on a clear cycle
    if (status_event) begin
      status_nxt[vcmg_pkg::STS_SUPPLY_OR_CODE_BIT] = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      code_r   <= vcmg_pkg::vcmg_code_reg_t'(vcmg_pkg::RST_VOLTAGE_CODE);
      status_r <= vcmg_pkg::RST_INT_STATUS;
      mask_r   <= vcmg_pkg::RST_INT_MASK;
      cfg5_r   <= vcmg_pkg::RST_CONFIG_FIVE;
    end else begin
      code_r   <= code_nxt;
      status_r <= status_nxt;
      mask_r   <= mask_nxt;
      cfg5_r   <= cfg5_nxt;
    end
  end

  // Alert while any unmasked status bit stands
  assign irq = |(status_r & ~mask_r);

  // AXI4-Lite read path
  logic [7:0] rd_idx;
  logic       rd_hit;
  logic [7:0] rd_byte;

  // One read in flight; address taken only while R is empty
  always_comb begin
    rvalid_nxt = rvalid_r;
    rdata_nxt  = rdata_r;
    rresp_nxt  = rresp_r;
    rd_idx     = s_axi_araddr[9:2];
    rd_hit     = (s_axi_araddr[1:0] == 2'h0) && ((s_axi_araddr >> 10) == '0);
    rd_byte    = 8'h00;
    unique case (rd_idx)
      vcmg_pkg::IDX_INT_STATUS_TWO: rd_byte = status_r;
      vcmg_pkg::IDX_VOLTAGE_CODE:   rd_byte = code_read;
      vcmg_pkg::IDX_INT_MASK_TWO:   rd_byte = mask_r;
      vcmg_pkg::IDX_CONFIG_FIVE:    rd_byte = cfg5_r;
      default: begin
        rd_hit = 1'b0;
      end
    endcase
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_nxt = 1'b1;
      rdata_nxt  = {24'h000000, rd_hit ? rd_byte : 8'h00};
      rresp_nxt  = rd_hit ? vcmg_pkg::RESP_OKAY : vcmg_pkg::RESP_DECERR;
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
  end

  assign s_axi_arready = ~rvalid_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

  // Bus state registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awaddr_r  <= '0;
      aw_full_r <= 1'b0;
      wdata_r   <= 8'h00;
      wlane0_r  <= 1'b0;
      w_full_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= vcmg_pkg::RESP_OKAY;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h00000000;
      rresp_r   <= vcmg_pkg::RESP_OKAY;
    end else begin
      awaddr_r  <= awaddr_nxt;
      aw_full_r <= aw_full_nxt;
      wdata_r   <= wdata_nxt;
      wlane0_r  <= wlane0_nxt;
      w_full_r  <= w_full_nxt;
      bvalid_r  <= bvalid_nxt;
      bresp_r   <= bresp_nxt;
      rvalid_r  <= rvalid_nxt;
      rdata_r   <= rdata_nxt;
      rresp_r   <= rresp_nxt;
    end
  end

  // Unused inputs: upper write lanes and the independent pin level
  logic unused_ok;
  assign unused_ok = ind_sync;
endmodule

// *** vcmg_sva.sv ***
// Purpose: Port-level checks for the voltage code monitor
// Assumes: One aclk domain, synchronous active-low reset
// Notes:   Bound to every vcmg_top instance
`timescale 1ns/1ns
module vcmg_sva (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [5:0]  voltage_code_o,
  input wire logic [5:0]  voltage_code_oe,
  input wire logic        independent_general_pin_o,
  input wire logic        independent_general_pin_oe,
  input wire logic        supply_out_of_limit,
  input wire logic        input_threshold_select,
  input wire logic        shared_pin_function_select,
  input wire logic        irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Pin mode switches all five dedicated lines together
  property p_oe_group; voltage_code_oe[4:0] == 5'h00 || voltage_code_oe[4:0] == 5'h1F; endproperty
  a_oe_group: assert property (p_oe_group) else $error("code pin enables split");
  property p_oe_shared; voltage_code_oe[5] |-> shared_pin_function_select && voltage_code_oe[0]; endproperty
  a_oe_shared: assert property (p_oe_shared) else $error("shared pin driven while measuring");
  // Alert only rises on a write, a supply fault or a code change
  property p_irq_cause;
    $rose(irq) |-> $rose(s_axi_bvalid) || $past(supply_out_of_limit) || $past(supply_out_of_limit, 2)
      || shared_pin_function_select;
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("alert without cause");
  // Pin controls move only at a write commit
  property p_pins_by_write;
    !$rose(s_axi_bvalid) |-> $stable({voltage_code_o, voltage_code_oe, independent_general_pin_o,
      independent_general_pin_oe, input_threshold_select, shared_pin_function_select});
  endproperty
  a_pins_by_write: assert property (p_pins_by_write) else $error("pin control moved without write");
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped early");
  property p_r_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_r_lat: assert property (p_r_lat) else $error("read answer late");
  property p_b_lat; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid; endproperty
  a_b_lat: assert property (p_b_lat) else $error("write answer late");
  // Eight-bit registers; refused reads return zero
  property p_r_data;
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000 && (s_axi_rresp != 2'h3 || s_axi_rdata == 32'h0);
  endproperty
  a_r_data: assert property (p_r_data) else $error("read data out of range");
  property p_ar_block; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_ar_block: assert property (p_ar_block) else $error("read taken while answer pending");
  c_irq: cover property ($rose(irq));
  c_decerr: cover property (s_axi_rvalid && s_axi_rresp == 2'h3);
  c_gpio: cover property (voltage_code_oe == 6'h3F);
endmodule

bind vcmg_top vcmg_sva i_sva (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready, .voltage_code_o, .voltage_code_oe, .independent_general_pin_o,
  .independent_general_pin_oe, .supply_out_of_limit, .input_threshold_select, .shared_pin_function_select, .irq);

// *** vcmg_vr_model.sv ***
// Purpose: Regulator side of the code lines and the independent pin
// Assumes: Regulator lets go of every line the device enables
// Notes:   Independent pin idles high through a pull-up
`timescale 1ns/1ns
module vcmg_vr_model (
  input  wire logic [5:0] code_req,
  input  wire logic [5:0] dev_o,
  input  wire logic [5:0] dev_oe,
  input  wire logic       ind_o,
  input  wire logic       ind_oe,
  output logic      [5:0] code_pin,
  output logic            ind_pin
);
  // Enabled lines follow the device, so the two never fight
  assign code_pin = (dev_oe & dev_o) | (~dev_oe & code_req);
  // Released pin falls back to the pull-up level
  assign ind_pin = ind_oe ? ind_o : 1'h1;
endmodule

// *** tb_top.sv ***
// Purpose: Register-level bench for the voltage code monitor
// Assumes: AXI4-Lite master tasks, 10 MHz clock
// Notes:   Waits of 250 cycles outlast the change window
`timescale 1ns/1ns
module tb_top;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic        supply_out_of_limit;
  logic [9:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata;
  logic [3:0]  s_axi_wstrb;
  logic [5:0]  code_req;
  wire logic   s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  wire logic   input_threshold_select, shared_pin_function_select, independent_general_pin_i;
  wire logic   independent_general_pin_o, independent_general_pin_oe;
  wire logic [1:0]  s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata;
  wire logic [5:0]  voltage_code_i, voltage_code_o, voltage_code_oe;
  int failures, cmp_count, cyc;

  vcmg_top i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .voltage_code_i, .voltage_code_o, .voltage_code_oe, .independent_general_pin_i,
    .independent_general_pin_o, .independent_general_pin_oe, .supply_out_of_limit,
    .input_threshold_select, .shared_pin_function_select, .irq);
  vcmg_vr_model i_vr (.code_req, .dev_o(voltage_code_o), .dev_oe(voltage_code_oe),
    .ind_o(independent_general_pin_o), .ind_oe(independent_general_pin_oe),
    .code_pin(voltage_code_i), .ind_pin(independent_general_pin_i));

  // Clock and hang guard
  always #50 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      report_and_stop();
    end
  end

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er = 2'h0,
                    input logic [3:0] st = 4'hF);
    @(posedge aclk);
    s_axi_awaddr <= {idx, 2'h0};
    s_axi_wdata <= {24'h000000, d};
    s_axi_wstrb <= st;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
    chk("bresp", 32'(er), 32'(s_axi_bresp));
  endtask

  task automatic rd(input logic [7:0] idx, input logic [7:0] e, input logic [1:0] er = 2'h0);
    @(posedge aclk);
    s_axi_araddr <= {idx, 2'h0};
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'h0;
    chk("rdata", {24'h000000, e}, s_axi_rdata);
    chk("rresp", 32'(er), 32'(s_axi_rresp));
  endtask

  initial begin
    aclk = 1'h0;
    aresetn = 1'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    supply_out_of_limit = 1'h0;
    s_axi_awaddr = 10'h000;
    s_axi_araddr = 10'h000;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    code_req = 6'h00;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    // Reset contents and an unmapped place
    rd(8'h42, 8'h00);
    rd(8'h43, 8'h00);
    rd(8'h75, 8'h00);
    rd(8'h7C, 8'h00);
    rd(8'h10, 8'h00, 2'h3);
    wr(8'h10, 8'hFF, 2'h3);
    // Low lane strobe off: write answered but ignored
    wr(8'h75, 8'h01, 2'h0, 4'h0);
    rd(8'h75, 8'h00);
    // Shared pin measuring supply: five lines read, changes not flagged
    code_req <= 6'h2A;
    cycles(250);
    rd(8'h43, 8'h0A);
    rd(8'h42, 8'h00);
    chk("sel", 32'h0, 32'(shared_pin_function_select));
    // Supply fault lands in status bit 0 and alerts
    supply_out_of_limit <= 1'h1;
    @(posedge aclk);
    supply_out_of_limit <= 1'h0;
    cycles(3);
    rd(8'h42, 8'h01);
    chk("irq", 32'h1, 32'(irq));
    wr(8'h42, 8'h01);
    chk("irq", 32'h0, 32'(irq));
    // Sixth line and reduced threshold
    wr(8'h43, 8'hC0);
    rd(8'h43, 8'hEA);
    chk("input_threshold_select", 32'h1, 32'(input_threshold_select));
    chk("sel", 32'h1, 32'(shared_pin_function_select));
    cycles(250);
    wr(8'h42, 8'h01);
    // Supply fault ignored while the shared pin carries code
    supply_out_of_limit <= 1'h1;
    cycles(150);
    rd(8'h42, 8'h00);
    supply_out_of_limit <= 1'h0;
    // Code change flagged inside the window, alert masked and unmasked
    code_req <= 6'h15;
    cycles(20);
    rd(8'h42, 8'h01);
    chk("irq", 32'h1, 32'(irq));
    wr(8'h75, 8'h01);
    chk("irq", 32'h0, 32'(irq));
    wr(8'h75, 8'h00);
    chk("irq", 32'h1, 32'(irq));
    cycles(250);
    wr(8'h42, 8'h01);
    // General pin mode turns code lines into outputs
    wr(8'h43, 8'hAA);
    wr(8'h7C, 8'h10);
    chk("oe", 32'h3F, 32'(voltage_code_oe));
    chk("pin", 32'h2A, 32'(voltage_code_i));
    wr(8'h43, 8'h15);
    chk("oe", 32'h1F, 32'(voltage_code_oe));
    chk("out", 32'h15, 32'(voltage_code_o));
    wr(8'h7C, 8'h1C);
    chk("ind", 32'h3, 32'({independent_general_pin_oe, independent_general_pin_i}));
    wr(8'h7C, 8'h08);
    chk("ind", 32'h2, 32'({independent_general_pin_oe, independent_general_pin_i}));
    report_and_stop();
  end
endmodule
